/* File: logic/opmode_pkg.sv */
package opmode_pkg;

  // =====================================================================
  // register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam logic [7:0]  ADDR_WAKE_FLAGS  = 8'h08;

  // =====================================================================
  // control register fields
  localparam int CTRL_STOP_EN      = 0;
  localparam int CTRL_IREF_STOP_EN = 1;
  localparam int CTRL_LV_EN        = 2;
  localparam int CTRL_LV_STOP_EN   = 3;
  localparam int CTRL_DEBUG_EN     = 4;
  localparam int CTRL_WAKE_PER_LO  = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [2:0]  WAKE_PERIOD_OFF = 3'h0;

  // =====================================================================
  // wake flag bits
  localparam int WF_KEYPAD = 0;
  localparam int WF_LVD    = 1;
  localparam int WF_CMP    = 2;
  localparam int WF_TIMER  = 3;
  localparam int WF_HALT   = 4;
  localparam int WF_IRQ    = 5;

  // =====================================================================
  // fixed address and opcode
  localparam logic [13:0] RESET_FETCH_ADDR = 14'h3ffd;
  localparam logic [7:0]  JUMP_OPCODE      = 8'hbc;

  // =====================================================================
  // debug command classes
  typedef enum logic [2:0] {
    CMD_MEM      = 3'b000,
    CMD_MEM_STAT = 3'b001,
    CMD_HALT     = 3'b010,
    CMD_REG      = 3'b011,
    CMD_TRACE    = 3'b100,
    CMD_GO       = 3'b101,
    CMD_FRESET   = 3'b110
  } dbg_cmd_t;

  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_RUN   = 3'b001,
    MODE_DEBUG_HALT_INSTRUCTION  = 3'b010,
    MODE_WAIT  = 3'b011,
    MODE_STOP  = 3'b100
  } op_mode_t;

endpackage

/* File: logic/cmd_filter_if.sv */
`timescale 1ns/100ps
interface cmd_filter_if;
  import opmode_pkg::*;
  op_mode_t mode;
  logic     cmd_valid;
  dbg_cmd_t cmd;
  logic     accept;
  logic     status_err;
  logic     reject;
  logic     stop_dbg;
  modport filter (input mode, input cmd_valid, input cmd, input stop_dbg,
                  output accept, output status_err, output reject);
  modport ctrl   (output mode, output cmd_valid, output cmd, output stop_dbg,
                  input accept, input status_err, input reject);
endinterface // cmd_filter_if

/* File: logic/debug_cmd_filter.sv */
`timescale 1ns/100ps
module debug_cmd_filter
  import opmode_pkg::*;
(
  cmd_filter_if.filter f
);
  // =====================================================================
  // command acceptance per mode
  wire is_nonintr = (f.cmd == CMD_MEM) || (f.cmd == CMD_MEM_STAT) || (f.cmd == CMD_HALT);
  wire low_power  = (f.mode == MODE_WAIT) || (f.mode == MODE_STOP);
  wire halt_ok    = (f.mode == MODE_WAIT) || ((f.mode == MODE_STOP) && f.stop_dbg);
  wire ok_run     = (f.mode == MODE_RUN) && is_nonintr;
  wire ok_debug_halt_instruction    = (f.mode == MODE_DEBUG_HALT_INSTRUCTION);
  wire ok_lp      = halt_ok && (f.cmd == CMD_HALT);
  wire ok_freset  = (f.mode == MODE_RUN) && (f.cmd == CMD_FRESET);
  assign f.accept     = f.cmd_valid && (ok_run || ok_debug_halt_instruction || ok_lp || ok_freset);
  assign f.status_err = f.cmd_valid && low_power && (f.cmd == CMD_MEM_STAT);
  assign f.reject     = f.cmd_valid && !f.accept && !f.status_err;
endmodule // debug_cmd_filter

/* File: logic/operating_mode_controller.sv */
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module operating_mode_controller
  import opmode_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_mode_select_debug_pin,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_insn_wait,
  input  wire logic        i_insn_stop,
  input  wire logic        i_debug_halt_instruction,
  input  wire logic        i_breakpoint,
  input  wire logic        i_irq,
  input  wire logic        i_keypad_irq,
  input  wire logic        i_lvd_irq,
  input  wire logic        i_cmp_irq,
  input  wire logic        i_timer_irq,
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_cmd_accept,
  output logic             o_cmd_status_err,
  output logic             o_cmd_reject,
  output logic             o_cpu_run,
  output logic             o_cpu_clk_en,
  output logic             o_sys_clk_en,
  output logic             o_clk_src_en,
  output logic             o_debug_clk_en,
  output logic             o_reg_full,
  output logic             o_bandgap_en,
  output logic             o_pin_hold,
  output logic             o_wake_timer_en,
  output logic             o_pc_load,
  output logic      [13:0] o_pc_value,
  output logic             o_pc_incr,
  output logic             o_ilop_reset,
  output logic      [2:0]  o_mode
);

  // =====================================================================
  // input synchronisers
  logic [1:0] ms_sync;
  logic [1:0] rp_sync;
  logic [1:0] kb_sync;
  logic [1:0] lv_sync;
  logic [1:0] cm_sync;
  wire        ms_pin   = ms_sync[1];
  wire        rpin_low = !rp_sync[1];
  wire        kb_irq   = kb_sync[1];
  wire        lv_irq   = lv_sync[1];
  wire        cm_irq   = cm_sync[1];

  always_ff @(posedge i_core_clk) begin
    ms_sync <= {ms_sync[0], i_mode_select_debug_pin};
    rp_sync <= {rp_sync[0], i_reset_pin_n};
    kb_sync <= {kb_sync[0], i_keypad_irq};
    lv_sync <= {lv_sync[0], i_lvd_irq};
    cm_sync <= {cm_sync[0], i_cmp_irq};
  end

  // =====================================================================
  // state and control
  op_mode_t    mode;
  op_mode_t    next_mode;
  logic [10:0] ctrl;
  logic [5:0]  wake_flags;
  logic        dbg_at_stop;
  logic        lv_at_stop;
  logic        iref_at_stop;

  wire       stop_en    = ctrl[CTRL_STOP_EN];
  wire       iref_en    = ctrl[CTRL_IREF_STOP_EN];
  wire       lv_both    = ctrl[CTRL_LV_EN] && ctrl[CTRL_LV_STOP_EN];
  wire       debug_en   = ctrl[CTRL_DEBUG_EN];
  wire [2:0] wake_per   = ctrl[CTRL_WAKE_PER_LO +: 3];
  wire       timer_on   = (wake_per != WAKE_PERIOD_OFF);
  wire       timer_wake = timer_on && i_timer_irq;

  // =====================================================================
  // debug command filter
  cmd_filter_if cfi ();
  assign cfi.mode      = mode;
  assign cfi.cmd_valid = i_cmd_valid;
  assign cfi.cmd       = dbg_cmd_t'(i_cmd);
  assign cfi.stop_dbg  = dbg_at_stop;
  debug_cmd_filter u_filter (
    .f (cfi)
  );
  assign o_cmd_accept     = cfi.accept;
  assign o_cmd_status_err = cfi.status_err;
  assign o_cmd_reject     = cfi.reject;

  wire halt_cmd  = cfi.accept && (cfi.cmd == CMD_HALT);
  wire go_cmd    = cfi.accept && (cfi.cmd == CMD_GO);
  wire freset    = cfi.accept && (cfi.cmd == CMD_FRESET);
  wire stop_halt = halt_cmd && dbg_at_stop;
  wire stop_irq  = kb_irq || lv_irq || cm_irq || timer_wake;
  wire enter_bg  = i_debug_halt_instruction || i_breakpoint;
  wire stop_ok   = i_insn_stop && stop_en;
  wire stop_bad  = i_insn_stop && !stop_en;

  // =====================================================================
  // mode transitions
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RESET: begin
        next_mode = ms_pin ? MODE_RUN : MODE_DEBUG_HALT_INSTRUCTION;
      end
      MODE_RUN: begin
        if (halt_cmd || enter_bg) begin
          next_mode = MODE_DEBUG_HALT_INSTRUCTION;
        end else if (i_insn_wait) begin
          next_mode = MODE_WAIT;
        end else if (stop_ok) begin
          next_mode = MODE_STOP;
        end
      end
      MODE_DEBUG_HALT_INSTRUCTION: begin
        if (go_cmd) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_WAIT: begin
        if (halt_cmd) begin
          next_mode = MODE_DEBUG_HALT_INSTRUCTION;
        end else if (i_irq || stop_irq) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (stop_halt) begin
          next_mode = MODE_DEBUG_HALT_INSTRUCTION;
        end else if (stop_irq) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RESET;
    endcase
  end

  wire sys_reset = !i_rst_n || stop_bad || freset || rpin_low;

  always_ff @(posedge i_core_clk) begin
    if (sys_reset) begin
      mode <= MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // =====================================================================
  // stop-entry snapshot of configuration
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      dbg_at_stop  <= 1'b0;
      lv_at_stop   <= 1'b0;
      iref_at_stop <= 1'b0;
    end else if (mode == MODE_RUN && next_mode == MODE_STOP) begin
      dbg_at_stop  <= debug_en;
      lv_at_stop   <= lv_both;
      iref_at_stop <= iref_en;
    end
  end

  // =====================================================================
  // wake flags, set wins over clear
  wire [5:0] wake_set;
  wire       in_lp = (mode == MODE_WAIT) || (mode == MODE_STOP);
  assign wake_set[WF_KEYPAD] = in_lp && kb_irq;
  assign wake_set[WF_LVD]    = in_lp && lv_irq;
  assign wake_set[WF_CMP]    = in_lp && cm_irq;
  assign wake_set[WF_TIMER]  = in_lp && timer_wake;
  assign wake_set[WF_HALT]   = in_lp && halt_cmd;
  assign wake_set[WF_IRQ]    = (mode == MODE_WAIT) && i_irq;

  // =====================================================================
  // apb slave
  wire        apb_wr    = i_psel && i_penable && i_pwrite;
  wire        hit_ctrl  = (i_paddr == ADDR_CTRL);
  wire        hit_stat  = (i_paddr == ADDR_STATUS);
  wire        hit_wf    = (i_paddr == ADDR_WAKE_FLAGS);
  wire        unmapped  = !(hit_ctrl || hit_stat || hit_wf);
  wire [31:0] rd_mux    = hit_ctrl ? {21'h0, ctrl} :
                          hit_stat ? {29'h0, mode} :
                          hit_wf   ? {26'h0, wake_flags} : 32'h0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (apb_wr && hit_ctrl) begin
      ctrl <= i_pwdata[10:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wake_flags <= 6'h00;
    end else begin
      wake_flags <= (wake_flags & ~((apb_wr && hit_wf) ? i_pwdata[5:0] : 6'h00))
                    | wake_set;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= rd_mux;
    end
  end

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && unmapped;

  // =====================================================================
  // clock, regulator and cpu controls
  wire in_stop = (mode == MODE_STOP);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_cpu_run       <= 1'b0;
      o_cpu_clk_en    <= 1'b0;
      o_sys_clk_en    <= 1'b1;
      o_clk_src_en    <= 1'b1;
      o_debug_clk_en  <= 1'b1;
      o_reg_full      <= 1'b1;
      o_bandgap_en    <= 1'b1;
      o_pin_hold      <= 1'b0;
      o_wake_timer_en <= 1'b0;
      o_pc_load       <= 1'b0;
      o_pc_value      <= 14'h0000;
      o_pc_incr       <= 1'b0;
      o_ilop_reset    <= 1'b0;
      o_mode          <= 3'h0;
    end else begin
      o_cpu_run       <= (mode == MODE_RUN);
      o_cpu_clk_en    <= (mode == MODE_RUN);
      o_sys_clk_en    <= !in_stop;
      o_clk_src_en    <= !in_stop || (iref_at_stop && lv_at_stop);
      o_debug_clk_en  <= !in_stop || dbg_at_stop;
      o_reg_full      <= !in_stop || dbg_at_stop || lv_at_stop;
      o_bandgap_en    <= !in_stop || lv_at_stop;
      o_pin_hold      <= in_lp;
      o_wake_timer_en <= timer_on;
      o_pc_load       <= (mode == MODE_RESET) && (next_mode == MODE_RUN) && !sys_reset;
      o_pc_value      <= RESET_FETCH_ADDR;
      o_pc_incr       <= in_lp && (next_mode == MODE_RUN) && !sys_reset;
      o_ilop_reset    <= stop_bad && (mode == MODE_RUN);
      o_mode          <= mode;
    end
  end

  // =====================================================================
  // assertions
  AST_WAIT_CPU_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_WAIT |=> !o_cpu_clk_en && o_sys_clk_en)
    else $error("cpu clocked or system clock off in wait");
  AST_BG_NO_RUN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_DEBUG_HALT_INSTRUCTION |=> !o_cpu_run)
    else $error("cpu runs in background mode");
  AST_RUN_FILTER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_RUN && i_cmd_valid && (i_cmd == CMD_REG || i_cmd == CMD_GO) |-> !o_cmd_accept)
    else $error("intrusive command accepted in run");
  AST_RUN_NONINTR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_RUN && i_cmd_valid && i_cmd == CMD_MEM |-> o_cmd_accept)
    else $error("memory command refused in run");
  AST_WAIT_STAT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_WAIT && i_cmd_valid && i_cmd == CMD_MEM_STAT
    |-> o_cmd_status_err && !o_cmd_accept)
    else $error("status command in wait without error");
  AST_WAIT_HALT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_WAIT && halt_cmd && !rpin_low |=> mode == MODE_DEBUG_HALT_INSTRUCTION)
    else $error("halt in wait did not enter background");
  AST_STOP_BAD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_RUN && stop_bad |=> o_ilop_reset && mode == MODE_RESET)
    else $error("illegal stop did not reset");
  AST_STOP_CLK: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop |=> !o_sys_clk_en && !o_cpu_clk_en)
    else $error("clocks running in stop");
  AST_TIMER_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop && wake_per == WAKE_PERIOD_OFF && !kb_irq && !lv_irq && !cm_irq
    && !halt_cmd && !rpin_low |=> in_stop)
    else $error("disabled timer woke from stop");
  AST_FLAG_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wake_flags[WF_TIMER] && !(apb_wr && hit_wf) |=> wake_flags[WF_TIMER])
    else $error("wake flag lost");
  AST_PC_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_RESET && ms_pin && !sys_reset |=> o_pc_load && o_pc_value == RESET_FETCH_ADDR)
    else $error("no reset fetch load on run entry");
  AST_PIN_LOW_BG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_RESET && !ms_pin && !sys_reset |=> mode == MODE_DEBUG_HALT_INSTRUCTION)
    else $error("low mode pin did not enter background");
  AST_WAIT_INCR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_WAIT && i_irq && !halt_cmd && !sys_reset |=> mode == MODE_RUN && o_pc_incr)
    else $error("interrupt in wait did not resume with increment");
  AST_WAIT_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mode == MODE_WAIT && i_cmd_valid && !(i_cmd == CMD_HALT || i_cmd == CMD_MEM_STAT)
    |-> o_cmd_reject)
    else $error("command not refused in wait");
  AST_STOP_STANDBY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop && !dbg_at_stop && !lv_at_stop |=> !o_reg_full && !o_clk_src_en)
    else $error("regulator or clock source on in plain stop");
  AST_STOP_DEBUG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop && dbg_at_stop |=> o_debug_clk_en && o_reg_full)
    else $error("debug clocks or regulation lost in stop");
  AST_STOP_LV: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop && lv_at_stop |=> o_reg_full && o_bandgap_en)
    else $error("regulator or reference off with low-voltage stop");
  AST_STOP_HALT_BG: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    in_stop && halt_cmd && !sys_reset |=> mode == MODE_DEBUG_HALT_INSTRUCTION)
    else $error("halt in stop did not enter background");
  AST_RESET_PIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    rpin_low |=> mode == MODE_RESET)
    else $error("reset pin did not reset");
  COV_PIN_BG:    cover property (@(posedge i_core_clk) mode == MODE_RESET ##1 mode == MODE_DEBUG_HALT_INSTRUCTION);
  COV_WAIT_EXIT: cover property (@(posedge i_core_clk) mode == MODE_WAIT ##1 mode == MODE_RUN);
  COV_STOP_BG:   cover property (@(posedge i_core_clk) mode == MODE_STOP ##1 mode == MODE_DEBUG_HALT_INSTRUCTION);
  COV_STOP_IRQ:  cover property (@(posedge i_core_clk) mode == MODE_STOP ##1 mode == MODE_RUN);

endmodule // operating_mode_controller

/* File: dv/debug_host_model.sv */
`timescale 1ns/100ps
module debug_host_model
  import opmode_pkg::*;
(
  input  wire logic       i_core_clk,
  output logic            o_cmd_valid,
  output logic      [2:0] o_cmd,
  input  wire logic       i_accept,
  input  wire logic       i_status_err,
  input  wire logic       i_reject
);
  // =====================================================================
  // idle: no command, class lines start at 3'h7; after each command they hold its inverse
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = 3'h7;
  end

  // =====================================================================
  // one command per call; answer taken at the edge that takes the command
  task automatic send(input dbg_cmd_t c, output logic acc, output logic serr,
                      output logic rej);
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b1;
    o_cmd       <= c;
    @(posedge i_core_clk);
    acc  = i_accept;
    serr = i_status_err;
    rej  = i_reject;
    o_cmd_valid <= 1'b0;
    o_cmd       <= ~c;
  endtask
endmodule // debug_host_model

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import opmode_pkg::*;
  logic clk = 0, rst_n = 0, ms_pin = 1, rst_pin_n = 1, irq = 0;
  logic [3:0] cpu_ev = '0;
  logic [3:0] wake = '0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [13:0] pc_value, pc_seen;
  logic [2:0] mode, cmd;
  logic pready, pslverr, acc, serr, rej, cpu_run, cpu_clk_en, sys_clk_en, clk_src_en;
  logic dbg_clk_en, reg_full, bandgap_en, pin_hold, timer_en, pc_load, pc_incr, ilop;
  logic cmd_valid;
  int n_errors = 0, total_checks = 0, n_incr = 0, n_load = 0, n_ilop = 0;
  logic [7:0] image [0:16383];

  // memory image: jump opcode at the reset fetch location
  initial image[RESET_FETCH_ADDR] = JUMP_OPCODE;

  always #2.5 clk = ~clk;

  operating_mode_controller operating_mode_controller_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_mode_select_debug_pin(ms_pin),
    .i_reset_pin_n(rst_pin_n), .i_insn_wait(cpu_ev[0]), .i_insn_stop(cpu_ev[1]),
    .i_debug_halt_instruction(cpu_ev[2]), .i_breakpoint(cpu_ev[3]), .i_irq(irq),
    .i_keypad_irq(wake[0]), .i_lvd_irq(wake[1]), .i_cmp_irq(wake[2]),
    .i_timer_irq(wake[3]), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cmd_accept(acc),
    .o_cmd_status_err(serr), .o_cmd_reject(rej), .o_cpu_run(cpu_run),
    .o_cpu_clk_en(cpu_clk_en), .o_sys_clk_en(sys_clk_en), .o_clk_src_en(clk_src_en),
    .o_debug_clk_en(dbg_clk_en), .o_reg_full(reg_full), .o_bandgap_en(bandgap_en),
    .o_pin_hold(pin_hold), .o_wake_timer_en(timer_en), .o_pc_load(pc_load),
    .o_pc_value(pc_value), .o_pc_incr(pc_incr), .o_ilop_reset(ilop), .o_mode(mode));

  debug_host_model debug_host_model_i (
    .i_core_clk(clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .i_accept(acc),
    .i_status_err(serr), .i_reject(rej));

  // =====================================================================
  // pulse counters
  always @(posedge clk) begin
    if (pc_incr === 1'b1) n_incr++;
    if (ilop === 1'b1) n_ilop++;
    if (pc_load === 1'b1) begin
      n_load++;
      pc_seen <= pc_value;
    end
  end

  // =====================================================================
  // compare and bus tasks
  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic dcmd(input dbg_cmd_t c, input logic ea, input logic es, input logic er);
    logic a, s, j;
    debug_host_model_i.send(c, a, s, j);
    chk_bit(a, ea);
    chk_bit(s, es);
    chk_bit(j, er);
  endtask
  task automatic wait_mode(input op_mode_t m);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mode !== m && n < 60);
    repeat (2) @(posedge clk);
    chk_word({29'h0, mode}, {29'h0, m});
  endtask
  task automatic cpu_pulse(input int i);
    @(posedge clk);
    cpu_ev[i] <= 1'b1;
    @(posedge clk);
    cpu_ev[i] <= 1'b0;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset_run();
    logic [31:0] r;
    logic e;
    wait_mode(MODE_RUN);
    chk_word(n_load, 1);
    chk_word({18'h0, pc_seen}, {18'h0, RESET_FETCH_ADDR});
    chk_word({24'h0, image[pc_seen]}, {24'h0, JUMP_OPCODE});
    rd(ADDR_CTRL, r);
    chk_word(r, {21'h0, CTRL_RESET});
    rd(ADDR_STATUS, r);
    chk_word(r[2:0], MODE_RUN);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk_bit(e, 1'b1);
    chk_word(r, 32'h0);
  endtask
  task automatic t_cmd_filter();
    dcmd(CMD_MEM, 1'b1, 1'b0, 1'b0);
    dcmd(CMD_MEM_STAT, 1'b1, 1'b0, 1'b0);
    for (int i = 3; i < 6; i++) dcmd(dbg_cmd_t'(i), 1'b0, 1'b0, 1'b1);
    dcmd(CMD_HALT, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_DEBUG_HALT_INSTRUCTION);
    chk_bit(cpu_run, 1'b0);
    for (int i = 0; i < 5; i++) dcmd(dbg_cmd_t'(i), 1'b1, 1'b0, 1'b0);
    dcmd(CMD_GO, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_RUN);
    chk_bit(cpu_run, 1'b1);
    for (int i = 2; i < 4; i++) begin
      cpu_pulse(i);
      wait_mode(MODE_DEBUG_HALT_INSTRUCTION);
      dcmd(CMD_GO, 1'b1, 1'b0, 1'b0);
      wait_mode(MODE_RUN);
    end
  endtask
  task automatic t_wait();
    logic [31:0] r;
    int k;
    wr(ADDR_WAKE_FLAGS, 32'h3f);
    rd(ADDR_WAKE_FLAGS, r);
    chk_word(r, 32'h0);
    cpu_pulse(0);
    wait_mode(MODE_WAIT);
    chk_bit(cpu_clk_en, 1'b0);
    chk_bit(sys_clk_en, 1'b1);
    chk_bit(clk_src_en, 1'b1);
    chk_bit(reg_full, 1'b1);
    chk_bit(pin_hold, 1'b1);
    dcmd(CMD_MEM, 1'b0, 1'b0, 1'b1);
    dcmd(CMD_MEM_STAT, 1'b0, 1'b1, 1'b0);
    dcmd(CMD_REG, 1'b0, 1'b0, 1'b1);
    k = n_incr;
    irq <= 1'b1;
    wait_mode(MODE_RUN);
    irq <= 1'b0;
    chk_word(n_incr, k + 1);
    rd(ADDR_WAKE_FLAGS, r);
    chk_bit(r[WF_IRQ], 1'b1);
    cpu_pulse(0);
    wait_mode(MODE_WAIT);
    dcmd(CMD_HALT, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_DEBUG_HALT_INSTRUCTION);
    dcmd(CMD_GO, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_RUN);
  endtask
  task automatic t_stop_plain();
    logic [31:0] r;
    int k;
    k = n_ilop;
    wr(ADDR_CTRL, 32'h0);
    cpu_pulse(1);
    wait_mode(MODE_RUN);
    chk_word(n_ilop, k + 1);
    wr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_WAKE_FLAGS, 32'h3f);
      cpu_pulse(1);
      wait_mode(MODE_STOP);
      chk_bit(cpu_clk_en, 1'b0);
      chk_bit(sys_clk_en, 1'b0);
      chk_bit(clk_src_en, 1'b0);
      chk_bit(reg_full, 1'b0);
      chk_bit(pin_hold, 1'b1);
      chk_bit(dbg_clk_en, 1'b0);
      chk_bit(bandgap_en, 1'b0);
      chk_bit(timer_en, 1'b0);
      dcmd(CMD_HALT, 1'b0, 1'b0, 1'b1);
      wake[3] <= 1'b1;
      repeat (6) @(posedge clk);
      wake[3] <= 1'b0;
      chk_word({29'h0, mode}, {29'h0, MODE_STOP});
      k = n_incr;
      wake[i] <= 1'b1;
      wait_mode(MODE_RUN);
      wake[i] <= 1'b0;
      chk_word(n_incr, k + 1);
      rd(ADDR_WAKE_FLAGS, r);
      chk_bit(r[i], 1'b1);
    end
  endtask
  task automatic t_stop_timer_dbg();
    int k;
    wr(ADDR_CTRL, 32'h101);
    cpu_pulse(1);
    wait_mode(MODE_STOP);
    chk_bit(timer_en, 1'b1);
    wake[3] <= 1'b1;
    wait_mode(MODE_RUN);
    wake[3] <= 1'b0;
    wr(ADDR_CTRL, 32'h1f);
    cpu_pulse(1);
    wait_mode(MODE_STOP);
    chk_bit(clk_src_en, 1'b1);
    chk_bit(reg_full, 1'b1);
    chk_bit(dbg_clk_en, 1'b1);
    chk_bit(bandgap_en, 1'b1);
    dcmd(CMD_MEM_STAT, 1'b0, 1'b1, 1'b0);
    dcmd(CMD_HALT, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_DEBUG_HALT_INSTRUCTION);
    dcmd(CMD_REG, 1'b1, 1'b0, 1'b0);
    dcmd(CMD_GO, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_RUN);
    wr(ADDR_CTRL, 32'h1);
    cpu_pulse(1);
    wait_mode(MODE_STOP);
    k = n_load;
    rst_pin_n <= 1'b0;
    wait_mode(MODE_RESET);
    rst_pin_n <= 1'b1;
    wait_mode(MODE_RUN);
    chk_word(n_load, k + 1);
    chk_word({18'h0, pc_seen}, {18'h0, RESET_FETCH_ADDR});
  endtask
  task automatic t_pin_low();
    ms_pin <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_mode(MODE_DEBUG_HALT_INSTRUCTION);
    ms_pin <= 1'b1;
    repeat (3) @(posedge clk);
    dcmd(CMD_FRESET, 1'b1, 1'b0, 1'b0);
    wait_mode(MODE_RUN);
  endtask

  // =====================================================================
  // run control
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_run();
    t_cmd_filter();
    t_wait();
    t_stop_plain();
    t_stop_timer_dbg();
    t_pin_low();
    conclude();
  end
endmodule // testbench
